// ---- pkg/ssp_cfg.svh ----
// Constants of the 8-bit synchronous serial port: control field positions,
// reset values, clock source codes and bit counts.
// Assumes inclusion by bare name from the design files.
`ifndef SSP_CFG_SVH
`define SSP_CFG_SVH

`define SSP_CTRL_SRC_HI 1
`define SSP_CTRL_SRC_LO 0
`define SSP_CTRL_FLOAT  2
`define SSP_CTRL_PINF   3
`define SSP_CTRL_POL    4
`define SSP_CTRL_LSB    5
`define SSP_CTRL_INT    6
`define SSP_CTRL_IDLE   7

`define SSP_CTRL_RST    8'h00
`define SSP_RATE_RST    8'h00
`define SSP_SR_RST      8'h00

`define SSP_SRC_DIV1    2'h0
`define SSP_SRC_DIV8    2'h1
`define SSP_SRC_DIV32   2'h2
`define SSP_PRE8_MAX    5'h07
`define SSP_PRE32_MAX   5'h1F

`define SSP_WORD_BITS   4'h8
`define SSP_LAST_BIT    4'h7

`endif

// ---- pkg/ssp_pkg.sv ----
// Types of the 8-bit synchronous serial port: states and the packed state
// records of each module.
// Assumes nothing of its surroundings.
package ssp_pkg;

   typedef enum logic [1:0] {SSP_IDLE, SSP_XFER, SSP_HOLD} ssp_state_t;

   typedef struct packed {
      ssp_state_t  st;
      logic [7:0]  ctrl;
      logic        armed;
      logic [7:0]  rate;
      logic [7:0]  sr;
      logic [3:0]  cnt;
      logic        ph;
      logic        sclk;
      logic        clk_prev;
      logic        dout;
      logic        doe;
      logic        irq;
      logic        busy;
      logic        sr_rdy;
      logic        clk_o;
      logic        clk_oe;
      logic        sdo;
      logic        sdo_oe;
   } ssp_top_st_t;

   typedef struct packed {
      logic [4:0]  pre;
      logic [7:0]  div;
      logic        tick;
   } ssp_gen_st_t;

   typedef struct packed {
      logic [7:0]  d0;
      logic [7:0]  d1;
      logic        v0;
      logic        v1;
   } ssp_buf_st_t;

endpackage

// ---- rtl/ssp_clkgen.sv ----
// Transfer clock generator: prescaler for the three serial sources and the
// rate divider, giving one tick per half transfer clock period.
// Assumes one clock, asynchronous high reset and a freezing clock enable.
`timescale 1ns/1ns
`default_nettype none
`include "ssp_cfg.svh"
module ssp_clkgen (
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   input  wire logic       ce_i,
   input  wire logic       run_i,
   input  wire logic       clr_i,
   input  wire logic [1:0] sel_i,
   input  wire logic [7:0] n_i,
   output logic            tick_o
);
   ssp_pkg::ssp_gen_st_t cur_r;
   ssp_pkg::ssp_gen_st_t cur_nxt;
   logic                 src;

   always_comb
   begin
      cur_nxt = cur_r;
      cur_nxt.tick = 1'b0;
      cur_nxt.pre = cur_r.pre + 5'h01;
      unique case (sel_i)
         `SSP_SRC_DIV1: src = 1'b1;
         `SSP_SRC_DIV8: src = ({2'h0, cur_r.pre[2:0]} == `SSP_PRE8_MAX);
         default:       src = (cur_r.pre == `SSP_PRE32_MAX);
      endcase
      // Half period is n+1 source periods, so a full period is 2(n+1).
      if (src)
      begin
         if (cur_r.div == n_i)
         begin
            cur_nxt.div = 8'h00;
            cur_nxt.tick = 1'b1;
         end
         else
         begin
            cur_nxt.div = cur_r.div + 8'h01;
         end
      end
      // Restart keeps the first half period full length after a start.
      if (!run_i || clr_i)
      begin
         cur_nxt = '0;
      end
   end

   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         cur_r <= '0;
      end
      else if (ce_i)
      begin
         cur_r <= cur_nxt;
      end
   end

   assign tick_o = cur_r.tick;

   AST_RATE_DIV: assert property (@(posedge clk_i) disable iff (rst_i)
      tick_o |-> ($past(cur_r.div) == $past(n_i)))
      else $error("Half period tick not at divisor end.");

endmodule
`default_nettype wire

// ---- rtl/ssp_buf.sv ----
// Two-entry buffer for received words, valid and ready on both sides.
// Assumes one clock, asynchronous high reset and a freezing clock enable.
`timescale 1ns/1ns
`default_nettype none
module ssp_buf (
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   input  wire logic       ce_i,
   input  wire logic       in_valid_i,
   input  wire logic [7:0] in_data_i,
   output logic            in_ready_o,
   output logic            out_valid_o,
   output logic [7:0]      out_data_o,
   input  wire logic       out_ready_i
);
   ssp_pkg::ssp_buf_st_t cur_r;
   ssp_pkg::ssp_buf_st_t cur_nxt;

   always_comb
   begin
      cur_nxt = cur_r;
      if (cur_r.v0 && out_ready_i)
      begin
         cur_nxt.d0 = cur_r.d1;
         cur_nxt.v0 = cur_r.v1;
         cur_nxt.v1 = 1'b0;
      end
      // Ready looks at the old state only, so a full buffer refuses a push
      // even in a cycle that also pops; no word is ever overwritten.
      if (in_valid_i && !cur_r.v1)
      begin
         if (!cur_nxt.v0)
         begin
            cur_nxt.d0 = in_data_i;
            cur_nxt.v0 = 1'b1;
         end
         else
         begin
            cur_nxt.d1 = in_data_i;
            cur_nxt.v1 = 1'b1;
         end
      end
   end

   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         cur_r <= '0;
      end
      else if (ce_i)
      begin
         cur_r <= cur_nxt;
      end
   end

   assign in_ready_o  = !cur_r.v1;
   assign out_valid_o = cur_r.v0;
   assign out_data_o  = cur_r.d0;

endmodule
`default_nettype wire

// ---- rtl/ssp_top.sv ----
// Eight-bit clock-synchronous serial port with internal or external clock.
// Assumes one clock, asynchronous high reset, synchronous pin inputs, and
// that software strobes are one-cycle pulses.
// Behaviour
// - Every internal-clock transfer moves exactly eight bits.
// - Internal clock is source over 2(n+1).
// - Source bit clear takes clock from pin.
// - Writing shift register starts the transfer.
// - Request on last pulse edge by polarity.
// - Bit order selects LSB or MSB first.
// - Polarity picks launch and capture edges.
// - External mode idle output level is programmable.
// - Shift while clocks come; internal stops eight.
// - Internal clock: hold last bit half period, then float.
// - Internal clock rests high or low by polarity.
// - Float bit puts data pin high impedance.
// - Control write only right after protect enable.
// - Pin function bit selects serial or port use.
`timescale 1ns/1ns
`default_nettype none
`include "ssp_cfg.svh"
module ssp_top (
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   input  wire logic       ce_i,
   input  wire logic       protect_write_enable_i,
   input  wire logic       ctrl_wr_i,
   input  wire logic [7:0] ctrl_wdata_i,
   output logic [7:0]      port_control_reg_o,
   input  wire logic       rate_wr_i,
   input  wire logic [7:0] rate_wdata_i,
   input  wire logic       sr_wr_i,
   input  wire logic [7:0] sr_wdata_i,
   output logic            sr_ready_o,
   output logic [7:0]      shift_register_o,
   output logic            busy_o,
   output logic            irq_o,
   input  wire logic       irq_clr_i,
   output logic            rx_valid_o,
   output logic [7:0]      rx_data_o,
   input  wire logic       rx_ready_i,
   input  wire logic       transfer_clock_pin_i,
   output logic            transfer_clock_pin_o,
   output logic            transfer_clock_pin_oe_o,
   input  wire logic       serial_data_in_pin_i,
   output logic            serial_data_out_pin_o,
   output logic            serial_data_out_pin_oe_o,
   input  wire logic       port_clk_out_i,
   input  wire logic       port_clk_oe_i,
   input  wire logic       port_data_out_i,
   input  wire logic       port_data_oe_i
);
   localparam ssp_pkg::ssp_top_st_t RST_ST = '{
      st:   ssp_pkg::SSP_IDLE,
      ctrl: `SSP_CTRL_RST,
      rate: `SSP_RATE_RST,
      sr:   `SSP_SR_RST,
      default: '0
   };

   ssp_pkg::ssp_top_st_t cur_r;
   ssp_pkg::ssp_top_st_t cur_nxt;
   logic                 tick;
   logic                 run;
   logic                 accept;
   logic                 push;
   logic                 buf_rdy;
   logic                 ext;
   logic                 pol;
   logic                 lsb;
   logic                 launch;
   logic                 cap;
   logic                 rise;
   logic                 fall;
   logic                 ser;
   logic                 flt;

   function automatic logic out_bit(input logic [7:0] sr,
                                    input logic       lsb_first);
      out_bit = lsb_first ? sr[0] : sr[7];
   endfunction

   function automatic logic [7:0] shift_in(input logic [7:0] sr,
                                           input logic       lsb_first,
                                           input logic       b);
      shift_in = lsb_first ? {b, sr[7:1]} : {sr[6:0], b};
   endfunction

   always_comb
   begin
      cur_nxt = cur_r;
      push = 1'b0;
      ext = !cur_r.ctrl[`SSP_CTRL_INT];
      pol = cur_r.ctrl[`SSP_CTRL_POL];
      lsb = cur_r.ctrl[`SSP_CTRL_LSB];
      rise = transfer_clock_pin_i && !cur_r.clk_prev;
      fall = !transfer_clock_pin_i && cur_r.clk_prev;
      // Clear source bit: the pin edges drive the shifter.
      if (ext)
      begin
         launch = pol ? rise : fall;
         cap = pol ? fall : rise;
      end
      else
      begin
         launch = tick && !cur_r.ph;
         cap = tick && cur_r.ph;
      end
      accept = sr_wr_i && cur_r.sr_rdy && buf_rdy;
      cur_nxt.clk_prev = transfer_clock_pin_i;

      // Any register write is the instruction after the protect write.
      if (ctrl_wr_i || rate_wr_i || sr_wr_i)
      begin
         cur_nxt.armed = 1'b0;
      end
      if (protect_write_enable_i)
      begin
         cur_nxt.armed = 1'b1;
      end
      if (ctrl_wr_i && cur_r.armed)
      begin
         cur_nxt.ctrl = ctrl_wdata_i;
      end
      if (rate_wr_i)
      begin
         cur_nxt.rate = rate_wdata_i;
      end
      if (irq_clr_i)
      begin
         cur_nxt.irq = 1'b0;
      end

      unique case (cur_r.st)
         ssp_pkg::SSP_IDLE:
         begin
            cur_nxt.sclk = !cur_nxt.ctrl[`SSP_CTRL_POL];
         end
         ssp_pkg::SSP_XFER:
         begin
            // A finished outside-clock word left here would hang our clock.
            if (!ext && cur_r.cnt == `SSP_WORD_BITS)
            begin
               cur_nxt.st = ssp_pkg::SSP_IDLE;
            end
            if (launch)
            begin
               cur_nxt.ph = 1'b1;
               cur_nxt.dout = out_bit(cur_r.sr, lsb);
               cur_nxt.doe = 1'b1;
               cur_nxt.sclk = pol;
            end
            if (cap)
            begin
               cur_nxt.ph = 1'b0;
               cur_nxt.sclk = !pol;
               cur_nxt.sr = shift_in(cur_r.sr, lsb,
                                     serial_data_in_pin_i);
               if (cur_r.cnt != `SSP_WORD_BITS)
               begin
                  cur_nxt.cnt = cur_r.cnt + 4'h1;
               end
               if (cur_r.cnt == `SSP_LAST_BIT)
               begin
                  cur_nxt.irq = 1'b1;
                  push = 1'b1;
                  // An outside clock keeps shifting; ours stops by itself.
                  if (!ext)
                  begin
                     cur_nxt.st = ssp_pkg::SSP_HOLD;
                  end
               end
            end
         end
         ssp_pkg::SSP_HOLD:
         begin
            if (tick)
            begin
               cur_nxt.st = ssp_pkg::SSP_IDLE;
               cur_nxt.doe = 1'b0;
            end
         end
         default:
         begin
            cur_nxt.st = ssp_pkg::SSP_IDLE;
         end
      endcase

      // A write during the hold time cuts it short and floats the pin.
      if (accept)
      begin
         cur_nxt.sr = sr_wdata_i;
         cur_nxt.st = ssp_pkg::SSP_XFER;
         cur_nxt.cnt = 4'h0;
         cur_nxt.ph = 1'b0;
         cur_nxt.doe = 1'b0;
         cur_nxt.sclk = !pol;
      end
      if (irq_clr_i && push)
      begin
         cur_nxt.irq = 1'b1;
      end

      ser = cur_nxt.ctrl[`SSP_CTRL_PINF];
      flt = cur_nxt.ctrl[`SSP_CTRL_FLOAT];
      cur_nxt.busy = (cur_nxt.st != ssp_pkg::SSP_IDLE) &&
                     !(!cur_nxt.ctrl[`SSP_CTRL_INT] &&
                       cur_nxt.cnt == `SSP_WORD_BITS);
      cur_nxt.sr_rdy = !cur_nxt.busy || (cur_nxt.st == ssp_pkg::SSP_HOLD);
      if (ser)
      begin
         cur_nxt.clk_o = cur_nxt.sclk;
         cur_nxt.clk_oe = !flt && cur_nxt.ctrl[`SSP_CTRL_INT];
         if (!cur_nxt.ctrl[`SSP_CTRL_INT] &&
             !cur_nxt.busy)
         begin
            cur_nxt.sdo = cur_nxt.ctrl[`SSP_CTRL_IDLE];
         end
         else
         begin
            cur_nxt.sdo = cur_nxt.dout;
         end
         cur_nxt.sdo_oe = !flt && (!cur_nxt.ctrl[`SSP_CTRL_INT] ||
                                   cur_nxt.doe);
      end
      else
      begin
         cur_nxt.clk_o = port_clk_out_i;
         cur_nxt.clk_oe = !flt && port_clk_oe_i;
         cur_nxt.sdo = port_data_out_i;
         cur_nxt.sdo_oe = !flt && port_data_oe_i;
      end
   end

   // Both the hold-off tick and the transfer ticks come from one divider.
   assign run = cur_r.ctrl[`SSP_CTRL_INT] &&
                (cur_r.st != ssp_pkg::SSP_IDLE);

   ssp_clkgen u_gen (
      .clk_i  (clk_i),
      .rst_i  (rst_i),
      .ce_i   (ce_i),
      .run_i  (run),
      .clr_i  (accept),
      .sel_i  (cur_r.ctrl[`SSP_CTRL_SRC_HI:`SSP_CTRL_SRC_LO]),
      .n_i    (cur_r.rate),
      .tick_o (tick)
   );

   ssp_buf u_buf (
      .clk_i       (clk_i),
      .rst_i       (rst_i),
      .ce_i        (ce_i),
      .in_valid_i  (push),
      .in_data_i   (cur_nxt.sr),
      .in_ready_o  (buf_rdy),
      .out_valid_o (rx_valid_o),
      .out_data_o  (rx_data_o),
      .out_ready_i (rx_ready_i)
   );

   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         cur_r <= RST_ST;
      end
      else if (ce_i)
      begin
         cur_r <= cur_nxt;
      end
   end

   assign port_control_reg_o       = cur_r.ctrl;
   assign shift_register_o         = cur_r.sr;
   assign sr_ready_o               = cur_r.sr_rdy;
   assign busy_o                   = cur_r.busy;
   assign irq_o                    = cur_r.irq;
   assign transfer_clock_pin_o     = cur_r.clk_o;
   assign transfer_clock_pin_oe_o  = cur_r.clk_oe;
   assign serial_data_out_pin_o    = cur_r.sdo;
   assign serial_data_out_pin_oe_o = cur_r.sdo_oe;

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   AST_IRQ_LAST: assert property (
      $rose(irq_o) |-> ($past(cur_r.cnt) == `SSP_LAST_BIT))
      else $error("Request raised on a bit other than the last.");

   AST_PUSH_IRQ: assert property (
      (ce_i && push) |=> (irq_o && rx_valid_o))
      else $error("Finished word gave no request or buffer entry.");

   AST_EIGHT: assert property (
      (cur_r.st == ssp_pkg::SSP_XFER ##1 cur_r.st == ssp_pkg::SSP_HOLD)
      |-> (cur_r.cnt == `SSP_WORD_BITS))
      else $error("Transfer ended without eight bits.");

   AST_IDLE_CLK: assert property (
      (cur_r.st == ssp_pkg::SSP_IDLE && transfer_clock_pin_oe_o &&
       cur_r.ctrl[`SSP_CTRL_PINF])
      |-> (transfer_clock_pin_o == !cur_r.ctrl[`SSP_CTRL_POL]))
      else $error("Idle transfer clock at wrong level.");

   AST_FLOAT: assert property (
      cur_r.ctrl[`SSP_CTRL_FLOAT] |-> !serial_data_out_pin_oe_o)
      else $error("Data pin driven while float bit set.");

   AST_PROTECT: assert property (
      $changed(cur_r.ctrl) |-> $past(cur_r.armed))
      else $error("Control changed without protect enable.");

   AST_START: assert property (
      (ce_i && accept) |=>
      (cur_r.st == ssp_pkg::SSP_XFER && cur_r.sr == $past(sr_wdata_i) &&
       busy_o))
      else $error("Shift register write did not start a transfer.");

   AST_HOLD_END: assert property (
      (ce_i && cur_r.st == ssp_pkg::SSP_HOLD && tick && !ctrl_wr_i &&
       !accept) |=> (!serial_data_out_pin_oe_o && !busy_o))
      else $error("Data pin still driven after hold time.");

   AST_SHIFT: assert property (
      (ce_i && cap && cur_r.st == ssp_pkg::SSP_XFER && !accept) |=>
      (cur_r.sr == shift_in($past(cur_r.sr), $past(lsb),
                            $past(serial_data_in_pin_i))))
      else $error("Capture edge did not shift the register.");

endmodule
`default_nettype wire

// ---- verification/ssp_peer.sv ----
// Far-side serial device: slave on the generated clock, or clock master.
// Assumes the bench resolves both pins and loads it while the clock idles.
`timescale 1ns/1ns
`default_nettype none
module ssp_peer (
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   input  wire logic       ext_i,
   input  wire logic       pol_i,
   input  wire logic       load_i,
   input  wire logic       go_i,
   input  wire logic [7:0] tx_i,
   input  wire logic [7:0] half_i,
   input  wire logic       sclk_i,
   input  wire logic       sdo_i,
   output logic            sclk_o,
   output logic            sclk_oe_o,
   output logic            sdi_o,
   output logic [7:0]      rx_o,
   output logic            done_o
);
   logic       prev_r;
   logic [7:0] tx_r;
   logic [7:0] hc_r;
   logic [4:0] tog_r;
   // The pin is driven only while the port expects an external clock.
   assign sclk_oe_o = ext_i;
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         prev_r <= 1'b1;
         tx_r   <= 8'h00;
         hc_r   <= 8'h00;
         tog_r  <= 5'h00;
         sclk_o <= 1'b1;
         sdi_o  <= 1'b0;
         rx_o   <= 8'h00;
         done_o <= 1'b0;
      end
      else
      begin
         prev_r <= sclk_i;
         if (prev_r != sclk_i && sclk_i == pol_i)
         begin
            sdi_o <= tx_r[7];
            // Refill with changing bits so stray captures never look idle.
            tx_r  <= {tx_r[6:0], ~tx_r[7]};
         end
         else if (load_i)
            tx_r <= tx_i;
         if (prev_r != sclk_i && sclk_i != pol_i)
            rx_o <= {rx_o[6:0], sdo_i};
         if (load_i)
            sclk_o <= ~pol_i;
         if (go_i)
         begin
            tog_r  <= 5'h10;
            hc_r   <= half_i;
            done_o <= 1'b0;
         end
         else if (tog_r != 5'h00)
         begin
            if (hc_r == 8'h01)
            begin
               sclk_o <= ~sclk_o;
               tog_r  <= tog_r - 5'h01;
               hc_r   <= half_i;
            end
            else
               hc_r <= hc_r - 8'h01;
         end
         else
            done_o <= 1'b1;
      end
   end
endmodule
`default_nettype wire

// ---- verification/tb_top.sv ----
// Self-checking bench of the serial port with a far-side device model.
// Assumes the port's pins resolve with a pull-up on the clock line.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
   logic clk_i = 1'b0, rst_i = 1'b1;
   logic pwe = 0, cwr = 0, rwr = 0, swr = 0, iclr = 0, rrdy = 0;
   logic pco = 0, pcoe = 0, pdo = 0, pdoe = 0, hold_rx = 0, drain = 0;
   logic [7:0] cwd = 0, rwd = 0, swd = 0, ctrl_rb, sr_q, rxd;
   logic srrdy, busy, irq, rxv, cko, ckoe, sdo, sdooe, sdo_last = 0;
   logic p_load = 0, p_go = 0, p_ext = 0, p_pol = 0, p_sck, p_sckoe;
   logic p_sdi, p_done, ck_prev = 0;
   logic [7:0] p_tx = 0, p_half = 8'h04, p_rx;
   logic [7:0] exp_q[$];
   logic [31:0] seed = 32'hE270;
   int mismatches = 0, total_checks = 0, pcnt = 0, per_r = 0;
   wire logic sck_pin = ckoe ? cko : (p_sckoe ? p_sck : 1'b1);
   // A released data line shows the inverse of its last driven level.
   wire logic sdo_pin = sdooe ? sdo : ~sdo_last;
   logic [7:0] cfg [5] = '{8'h48, 8'h79, 8'h6A, 8'h5B, 8'h48};
   logic [7:0] nv [5] = '{8'h02, 8'h00, 8'h00, 8'h01, 8'hFF};

   ssp_top u_ssp_top (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1),
      .protect_write_enable_i(pwe), .ctrl_wr_i(cwr), .ctrl_wdata_i(cwd),
      .port_control_reg_o(ctrl_rb), .rate_wr_i(rwr), .rate_wdata_i(rwd),
      .sr_wr_i(swr), .sr_wdata_i(swd), .sr_ready_o(srrdy),
      .shift_register_o(sr_q), .busy_o(busy), .irq_o(irq),
      .irq_clr_i(iclr), .rx_valid_o(rxv), .rx_data_o(rxd),
      .rx_ready_i(rrdy), .transfer_clock_pin_i(sck_pin),
      .transfer_clock_pin_o(cko), .transfer_clock_pin_oe_o(ckoe),
      .serial_data_in_pin_i(p_sdi), .serial_data_out_pin_o(sdo),
      .serial_data_out_pin_oe_o(sdooe), .port_clk_out_i(pco),
      .port_clk_oe_i(pcoe), .port_data_out_i(pdo), .port_data_oe_i(pdoe));
   ssp_peer u_ssp_peer (.clk_i(clk_i), .rst_i(rst_i), .ext_i(p_ext),
      .pol_i(p_pol), .load_i(p_load), .go_i(p_go), .tx_i(p_tx),
      .half_i(p_half), .sclk_i(sck_pin), .sdo_i(sdo_pin), .sclk_o(p_sck),
      .sclk_oe_o(p_sckoe), .sdi_o(p_sdi), .rx_o(p_rx), .done_o(p_done));

   initial
   begin
      forever #10 clk_i = ~clk_i;
   end

   function logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   function logic [7:0] rev8(input logic [7:0] v);
      for (int i = 0; i < 8; i++) rev8[i] = v[7 - i];
   endfunction

   task final_report();
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   task check(input string name, input logic [15:0] seen,
              input logic [15:0] expv);
      total_checks++;
      if (seen !== expv)
      begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", name, expv, seen);
      end
   endtask

   task cyc(input int n);
      repeat (n) @(negedge clk_i);
   endtask

   task ctrl_wr(input logic [7:0] d, input bit arm);
      if (arm)
      begin
         pwe = 1;
         cyc(1);
         pwe = 0;
      end
      cwr = 1;
      cwd = d;
      cyc(1);
      cwr = 0;
   endtask

   task rate_wr(input logic [7:0] d);
      rwr = 1;
      rwd = d;
      cyc(1);
      rwr = 0;
   endtask

   task sr_wr(input logic [7:0] d);
      swr = 1;
      swd = d;
      cyc(1);
      swr = 0;
   endtask

   task wait_for(input int ext);
      int i;
      for (i = 0; i < 20000; i++)
      begin
         if (ext == 2 ? irq === 1'b1 :
             (ext == 1 ? p_done === 1'b1 : busy === 1'b0))
            break;
         cyc(1);
      end
      if (i == 20000)
      begin
         mismatches++;
         final_report();
      end
   endtask

   task load_peer(input logic [7:0] d);
      p_tx = d;
      p_load = 1;
      cyc(1);
      p_load = 0;
      cyc(2);
   endtask

   task xfer_int(input logic [7:0] c, input logic [7:0] n);
      logic [31:0] r;
      int h2;
      logic [7:0] e;
      h2 = 2 * (n + 1) * (c[1:0] == 2'h0 ? 1 : (c[1:0] == 2'h1 ? 8 : 32));
      r = xs();
      ctrl_wr(c, 1);
      rate_wr(n);
      cyc(3);
      p_pol = c[4];
      load_peer(r[15:8]);
      e = c[5] ? rev8(r[15:8]) : r[15:8];
      exp_q.push_back(e);
      sr_wr(r[7:0]);
      cyc(1);
      check("busy", 16'(busy), 16'h0001);
      check("sr_ready", 16'(srrdy), 16'h0000);
      sr_wr(~r[7:0]);
      wait_for(0);
      check("peer_rx", 16'(p_rx), 16'(c[5] ? rev8(r[7:0]) : r[7:0]));
      check("shift_reg", 16'(sr_q), 16'(e));
      check("irq", 16'(irq), 16'h0001);
      check("period", per_r[15:0], h2[15:0]);
      check("clk_rest", 16'(cko), 16'(!c[4]));
      check("clk_oe", 16'(ckoe), 16'h0001);
      check("sdo_oe", 16'(sdooe), 16'h0000);
      iclr = 1;
      cyc(1);
      iclr = 0;
      cyc(1);
      check("irq_clr", 16'(irq), 16'h0000);
   endtask

   always @(posedge clk_i)
   begin
      ck_prev <= cko;
      if (sdooe === 1'b1)
         sdo_last <= sdo;
      if (cko === 1'b1 && ck_prev === 1'b0)
      begin
         per_r <= pcnt;
         pcnt <= 1;
      end
      else
         pcnt <= pcnt + 1;
      if (rxv === 1'b1 && rrdy === 1'b1)
      begin
         if (exp_q.size() == 0)
            check("rx_extra", 16'h0001, 16'h0000);
         else
            check("rx_data", 16'(rxd), 16'(exp_q.pop_front()));
      end
   end

   always @(negedge clk_i)
      rrdy <= !hold_rx && (drain || (pcnt[2] ^ seed[3]));

   initial
   begin
      repeat (100000) @(posedge clk_i);
      mismatches++;
      final_report();
   end

   initial
   begin
      logic [31:0] r;
      repeat (4) @(negedge clk_i);
      rst_i = 0;
      cyc(2);
      check("ctrl_rst", 16'(ctrl_rb), 16'h0000);
      check("busy_rst", 16'(busy), 16'h0000);
      ctrl_wr(8'h5A, 0);
      cyc(1);
      check("ctrl_unarmed", 16'(ctrl_rb), 16'h0000);
      pwe = 1;
      cyc(1);
      pwe = 0;
      rate_wr(8'h03);
      ctrl_wr(8'h5A, 0);
      cyc(1);
      check("ctrl_spent", 16'(ctrl_rb), 16'h0000);
      ctrl_wr(8'h5A, 1);
      cyc(1);
      check("ctrl_armed", 16'(ctrl_rb), 16'h005A);
      r = xs();
      {pco, pcoe, pdo, pdoe} = r[3:0];
      ctrl_wr(8'h00, 1);
      cyc(2);
      check("port_clk", 16'({cko, ckoe}), 16'({pco, pcoe}));
      check("port_data", 16'({sdo, sdooe}), 16'({pdo, pdoe}));
      pdoe = 1;
      ctrl_wr(8'h04, 1);
      cyc(2);
      check("float", 16'(sdooe), 16'h0000);
      for (int k = 0; k < 5; k++) xfer_int(cfg[k], nv[k]);
      drain = 1;
      cyc(4);
      hold_rx = 1;
      xfer_int(8'h48, 8'h02);
      xfer_int(8'h48, 8'h02);
      sr_wr(8'h3C);
      cyc(1);
      check("full_busy", 16'(busy), 16'h0000);
      check("full_ready", 16'(srrdy), 16'h0001);
      check("full_sr", 16'(sr_q), 16'(exp_q[$]));
      hold_rx = 0;
      cyc(5);
      check("drained", 16'(exp_q.size()), 16'h0000);
      // A write in the hold time starts the next word at once.
      r = xs();
      load_peer(r[15:8]);
      exp_q.push_back(r[15:8]);
      exp_q.push_back(~r[15:8]);
      sr_wr(r[23:16]);
      wait_for(2);
      sr_wr(r[7:0]);
      check("hold_cut", 16'({sdooe, busy}), 16'h0001);
      wait_for(0);
      check("cut_rx", 16'(p_rx), 16'(r[7:0]));
      iclr = 1;
      cyc(1);
      iclr = 0;
      cyc(4);
      ctrl_wr(8'h88, 1);
      cyc(2);
      check("idle_hi", 16'({sdo, sdooe}), 16'h0003);
      check("ext_clk_oe", 16'(ckoe), 16'h0000);
      ctrl_wr(8'h08, 1);
      cyc(2);
      check("idle_lo", 16'(sdo), 16'h0000);
      p_pol = 0;
      p_ext = 1;
      r = xs();
      load_peer(r[15:8]);
      exp_q.push_back(r[15:8]);
      sr_wr(r[7:0]);
      p_go = 1;
      cyc(1);
      p_go = 0;
      wait_for(1);
      cyc(3);
      check("ext_peer_rx", 16'(p_rx), 16'(r[7:0]));
      check("ext_shift", 16'(sr_q), 16'(r[15:8]));
      check("ext_busy", 16'(busy), 16'h0000);
      check("ext_irq", 16'(irq), 16'h0001);
      cyc(5);
      check("left", 16'(exp_q.size()), 16'h0000);
      final_report();
   end
endmodule
`default_nettype wire
